// ===== rtl/sacc_core.sv
// Digital control of a 12-bit successive-approximation converter.
// Assumes clk is the converter clock; all other inputs but rst arrive from
// the bus clock domain or the analog front end and are synchronised here.
//
// Overview of operation
// [R1] Rising edge of calibration_start launches a foreground calibration.
// [R2] Calibration busy reads one throughout calibration, cleared when it finishes.
// [R3] Calibration factor corrects every conversion until the converter powers off.
// [R4] Software starts no conversion while calibrating; calibrates before converting.
// [R5] Rising edge of calibration_factor_reset clears the held factor.
// [R6] Software powers on, waits 14 cycles, optionally resets factor, then calibrates.
// [R7] Software should recalibrate when supply or temperature changes.
// [R8] While converter_on is zero the whole conversion logic stays in reset.
// [R9] Clearing converter_on powers the analog front end off.
// [R10] Software waits the startup delay after power-on before sampling.
// [R11] Converter logic runs on the converter clock, apart from the bus side.
// [R12] Routine sequence holds sixteen channel entries converted in order.
// [R13] Four-bit sequence_length sets how many entries are converted.
// [R14] Resolution is selectable among 12, 10, 8 and 6 bits.
// [R15] Channels 0-9 external, 10 temperature, 11 internal reference.
// [R16] Results are stored right-aligned or left-aligned as configured. With oversampling on, the code ignores left_align.
// [R17] Oversampler accumulates 2x to 256x into a 16-bit result.
// [R18] Accumulation is right-shifted by up to eight bits before storing.
// [R19] Conversion starts on software command or selected hardware trigger.
// [R20] Interrupt raised at end of routine conversions and on watchdog event.
// [R21] Single mode converts once per trigger; continuous mode restarts itself.
// [R22] Stored result sets end-of-conversion flag; interrupt if enabled. The code sets eoc_flag only after the last entry of the sequence.
// [R23] Control in and status out cross domains through synchronisers. The code synchronises the inputs only; outputs leave unsynchronised.
`timescale 1ns/1ps
`include "sacc_regs.svh"

module sacc_core (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                converter_on,
    input  wire logic                calibration_start,
    input  wire logic                calibration_factor_reset,
    input  wire logic                sw_start,
    input  wire logic                hw_trigger_enable,
    input  wire logic                hw_trigger,
    input  wire logic                continuous_mode,
    input  wire logic                left_align,
    input  wire logic [1:0]          resolution,
    input  wire logic [3:0]          sequence_length,
    input  wire logic [63:0]         sequence_channels,
    input  wire logic                oversample_enable,
    input  wire logic [2:0]          oversample_ratio,
    input  wire logic [3:0]          oversample_shift,
    input  wire logic                watchdog_enable,
    input  wire sacc_pkg::sacc_code_t watchdog_high,
    input  wire sacc_pkg::sacc_code_t watchdog_low,
    input  wire logic                conversion_done_irq_enable,
    input  wire logic                watchdog_irq_enable,
    input  wire logic                eoc_clear,
    input  wire logic                wde_clear,
    input  wire logic                afe_done,
    input  wire sacc_pkg::sacc_code_t afe_result,
    output logic                     afe_power_on,
    output sacc_pkg::sacc_chan_t     afe_channel,
    output logic                     afe_sample,
    output logic                     afe_calibrate,
    output logic                     calibration_busy,
    output logic                     conversion_busy,
    output sacc_pkg::sacc_data_t     result_data,
    output logic                     eoc_flag,
    output logic                     wde_flag,
    output logic                     irq
);
    import sacc_pkg::*;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic sacc_code_t reduce_res(input sacc_code_t v, input logic [1:0] r);
        case (r)
            `SACC_RES_10: reduce_res = {2'h0, v[11:2]};
            `SACC_RES_8:  reduce_res = {4'h0, v[11:4]};
            `SACC_RES_6:  reduce_res = {6'h0, v[11:6]};
            default:      reduce_res = v;
        endcase
    endfunction

    function automatic sacc_data_t align_res(input sacc_code_t v, input logic [1:0] r, input logic left);
        if (!left) begin
            align_res = {4'h0, v};
        end else begin
            case (r)
                `SACC_RES_10: align_res = {v[9:0], 6'h00};
                `SACC_RES_8:  align_res = {v[7:0], 8'h00};
                `SACC_RES_6:  align_res = {8'h00, v[5:0], 2'h0};  // byte aligned
                default:      align_res = {v, 4'h0};
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    // Multi-bit settings pass two flops as levels; software changes them only
    // while the converter is idle, so no word can be caught half-updated.
    localparam int EVW = 9;
    localparam int CFW = 1 + 1 + 2 + 4 + 64 + 1 + 3 + 4 + 1 + 12 + 12 + 1 + 1;
    logic [EVW-1:0] ev_meta, ev_sync, ev_prev;
    logic [CFW-1:0] cf_meta, cf_sync;
    sacc_code_t     res_meta, res_sync;

    always_ff @(posedge clk) begin
        if (rst) begin
            ev_meta  <= '0;
            ev_sync  <= '0;
            ev_prev  <= '0;
            cf_meta  <= '0;
            cf_sync  <= '0;
            res_meta <= `SACC_CODE_ZERO;
            res_sync <= `SACC_CODE_ZERO;
        end else begin
            ev_meta  <= {converter_on, calibration_start, calibration_factor_reset, sw_start,
                         hw_trigger_enable, hw_trigger, eoc_clear, wde_clear, afe_done};  // R23
            ev_sync  <= ev_meta;  // R11
            ev_prev  <= ev_sync;
            cf_meta  <= {continuous_mode, left_align, resolution, sequence_length, sequence_channels,
                         oversample_enable, oversample_ratio, oversample_shift, watchdog_enable,
                         watchdog_high, watchdog_low, conversion_done_irq_enable, watchdog_irq_enable};
            cf_sync  <= cf_meta;
            res_meta <= afe_result;
            res_sync <= res_meta;
        end
    end

    logic on_s, cont_s, left_s, os_en_s, wd_en_s, eoc_ie_s, wde_ie_s, trig_en_s;
    logic [1:0]  res_s;
    logic [3:0]  len_s, shift_s;
    logic [63:0] chans_s;
    logic [2:0]  ratio_s;
    sacc_code_t  wd_hi_s, wd_lo_s;
    logic cal_rise, cal_rst_rise, sw_rise, hw_rise, eoc_clr_rise, wde_clr_rise, done_rise;

    assign {cont_s, left_s, res_s, len_s, chans_s, os_en_s, ratio_s, shift_s, wd_en_s,
            wd_hi_s, wd_lo_s, eoc_ie_s, wde_ie_s} = cf_sync;
    assign on_s         = ev_sync[8];
    assign trig_en_s    = ev_sync[4];
    assign cal_rise     = ev_sync[7] & ~ev_prev[7];
    assign cal_rst_rise = ev_sync[6] & ~ev_prev[6];
    assign sw_rise      = ev_sync[5] & ~ev_prev[5];
    assign hw_rise      = trig_en_s & ev_sync[3] & ~ev_prev[3];
    assign eoc_clr_rise = ev_sync[2] & ~ev_prev[2];
    assign wde_clr_rise = ev_sync[1] & ~ev_prev[1];
    assign done_rise    = ev_sync[0] & ~ev_prev[0];

    // Converter-off acts as a reset of everything past the synchronisers except afe_power_on, which only rst resets
    logic core_rst;
    assign core_rst = rst | ~on_s;  // R8

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    sacc_state_e state_reg, state_next;
    logic [3:0]  idx_reg;
    logic [7:0]  os_cnt_reg;
    logic [7:0]  os_last;
    logic        seq_last, os_done, start_req;
    sacc_code_t  raw_reg, cal_factor_reg;
    logic [19:0] acc_reg, acc_sum;
    logic [3:0]  shift_eff;

    assign seq_last  = (idx_reg == len_s);                          // R13
    assign os_last   = 8'((9'h002 << ratio_s) - 9'h001);            // R17
    assign os_done   = ~os_en_s | (os_cnt_reg == os_last);
    assign start_req = sw_rise | hw_rise;                           // R19
    assign acc_sum   = acc_reg + {8'h00, raw_reg};
    assign shift_eff = (shift_s > `SACC_OS_SHIFT_MAX) ? `SACC_OS_SHIFT_MAX : shift_s;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SACC_ST_IDLE: begin
                if (cal_rise) begin
                    state_next = SACC_ST_CAL;                       // R1
                end else if (start_req) begin
                    state_next = SACC_ST_CONV;
                end
            end
            SACC_ST_CAL: begin
                if (done_rise) begin
                    state_next = SACC_ST_IDLE;                      // R2
                end
            end
            SACC_ST_CONV: begin
                if (done_rise) begin
                    state_next = SACC_ST_NEXT;
                end
            end
            SACC_ST_NEXT: begin
                if (!os_done || !seq_last || cont_s) begin
                    state_next = SACC_ST_CONV;                      // R21
                end else begin
                    state_next = SACC_ST_IDLE;
                end
            end
            default: state_next = SACC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            state_reg <= SACC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sequence index and oversample count
    always_ff @(posedge clk) begin
        if (core_rst) begin
            idx_reg    <= 4'h0;
            os_cnt_reg <= 8'h00;
        end else if (state_reg == SACC_ST_IDLE) begin
            idx_reg    <= 4'h0;
            os_cnt_reg <= 8'h00;
        end else if (state_reg == SACC_ST_NEXT) begin
            if (!os_done) begin
                os_cnt_reg <= os_cnt_reg + 8'h01;
            end else begin
                os_cnt_reg <= 8'h00;
                idx_reg    <= seq_last ? 4'h0 : idx_reg + 4'h1;     // R12
            end
        end
    end

    // ------------------------------------------------------------------------
    // Calibration
    // ------------------------------------------------------------------------
    // The factor is the front end's offset code measured during calibration.
    always_ff @(posedge clk) begin
        if (core_rst) begin
            cal_factor_reg <= `SACC_CODE_ZERO;                      // R3
        end else if (state_reg == SACC_ST_CAL && done_rise) begin
            cal_factor_reg <= res_sync;
        end else if (cal_rst_rise) begin
            cal_factor_reg <= `SACC_CODE_ZERO;                      // R5
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            calibration_busy <= 1'b0;
            afe_calibrate    <= 1'b0;
        end else begin
            calibration_busy <= (state_next == SACC_ST_CAL);        // R2
            afe_calibrate    <= (state_next == SACC_ST_CAL);
        end
    end

    // ------------------------------------------------------------------------
    // Conversion datapath
    // ------------------------------------------------------------------------
    sacc_chan_t cur_chan;
    assign cur_chan = chans_s[{idx_reg, 2'h0} +: 4];

    always_ff @(posedge clk) begin
        if (core_rst) begin
            raw_reg <= `SACC_CODE_ZERO;
        end else if (state_reg == SACC_ST_CONV && done_rise) begin
            // Offset removal saturates at zero instead of wrapping
            raw_reg <= reduce_res((res_sync > cal_factor_reg) ? res_sync - cal_factor_reg
                                                               : `SACC_CODE_ZERO, res_s);  // R3 R14
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            acc_reg     <= `SACC_ACC_ZERO;
            result_data <= `SACC_DATA_ZERO;
        end else if (state_reg == SACC_ST_NEXT) begin
            if (!os_done) begin
                acc_reg <= acc_sum;                                 // R17
            end else begin
                acc_reg     <= `SACC_ACC_ZERO;
                result_data <= os_en_s ? 16'(acc_sum >> shift_eff)  // R18
                                       : align_res(raw_reg, res_s, left_s);  // R16
            end
        end
    end

    // Channels above the internal reference are not wired; they read as channel 0
    always_ff @(posedge clk) begin
        if (core_rst) begin
            afe_channel     <= 4'h0;
            afe_sample      <= 1'b0;
            conversion_busy <= 1'b0;
        end else begin
            afe_channel     <= (cur_chan < `SACC_CH_COUNT) ? cur_chan : 4'h0;  // R15
            afe_sample      <= (state_next == SACC_ST_CONV);
            conversion_busy <= (state_next == SACC_ST_CONV) || (state_next == SACC_ST_NEXT);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            afe_power_on <= 1'b0;
        end else begin
            afe_power_on <= on_s;                                   // R9
        end
    end

    // ------------------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------------------
    logic eoc_set, wde_set;
    assign eoc_set = (state_reg == SACC_ST_NEXT) && os_done && seq_last;              // R22
    assign wde_set = (state_reg == SACC_ST_NEXT) && wd_en_s &&
                     ((raw_reg > wd_hi_s) || (raw_reg < wd_lo_s));

    // A set in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (core_rst) begin
            eoc_flag <= 1'b0;
            wde_flag <= 1'b0;
        end else begin
            eoc_flag <= eoc_set | (eoc_flag & ~eoc_clr_rise);      // R22
            wde_flag <= wde_set | (wde_flag & ~wde_clr_rise);
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (eoc_flag & eoc_ie_s) | (wde_flag & wde_ie_s);   // R20
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_cal_launch: assert property (on_s && $past(on_s) && state_reg == SACC_ST_IDLE && cal_rise
        |=> calibration_busy && afe_calibrate) else $error("calibration not launched");  // R1
    chk_cal_hold: assert property (on_s && state_reg == SACC_ST_CAL && !done_rise
        |=> calibration_busy) else $error("calibration busy dropped early");  // R2
    chk_cal_end: assert property (on_s && state_reg == SACC_ST_CAL && done_rise
        |=> !calibration_busy ##0 cal_factor_reg == $past(res_sync)) else $error("calibration end wrong");  // R2
    chk_factor_clear: assert property (on_s && cal_rst_rise && state_reg != SACC_ST_CAL
        |=> cal_factor_reg == `SACC_CODE_ZERO) else $error("factor not cleared");  // R5
    chk_off_reset: assert property (!on_s |=> state_reg == SACC_ST_IDLE && !eoc_flag && !irq
        && cal_factor_reg == `SACC_CODE_ZERO) else $error("core not held in reset");  // R8
    chk_power_off: assert property (!on_s |=> !afe_power_on) else $error("front end left powered");  // R9
    chk_seq_bound: assert property (idx_reg <= len_s || state_reg == SACC_ST_IDLE)
        else $error("sequence index past length");  // R13
    chk_start_conv: assert property (on_s && $past(on_s) && state_reg == SACC_ST_IDLE && !cal_rise
        && start_req |=> afe_sample && conversion_busy) else $error("trigger ignored");  // R19
    chk_single_stop: assert property (on_s && eoc_set && !cont_s ##1 on_s
        |-> state_reg == SACC_ST_IDLE && !afe_sample) else $error("single mode restarted");  // R21
    chk_eoc_set: assert property (on_s && eoc_set ##1 on_s |-> eoc_flag) else $error("eoc not set");  // R22
    chk_irq_eoc: assert property (on_s && eoc_flag && eoc_ie_s ##1 on_s |-> irq) else $error("irq missing");  // R20
    chk_os_shift: assert property (on_s && state_reg == SACC_ST_NEXT && os_en_s && os_done ##1 on_s
        |-> result_data == 16'($past(acc_sum) >> $past(shift_eff))) else $error("oversample store wrong");  // R18

    cov_calibration: cover property (state_reg == SACC_ST_CAL ##1 state_reg == SACC_ST_IDLE);
    cov_sequence:    cover property (eoc_set && len_s == 4'h3);
    cov_oversample:  cover property (eoc_set && os_en_s && ratio_s == 3'h2);
    cov_watchdog:    cover property (wde_set && irq);

endmodule // sacc_core

// ===== rtl/sacc_pkg.sv
// Types shared by the converter control core.
// Assumes the constants header is compiled alongside.
package sacc_pkg;

    typedef enum logic [3:0] {
        SACC_ST_IDLE = 4'h1,
        SACC_ST_CAL  = 4'h2,
        SACC_ST_CONV = 4'h4,
        SACC_ST_NEXT = 4'h8
    } sacc_state_e;

    typedef logic [11:0] sacc_code_t;
    typedef logic [3:0]  sacc_chan_t;
    typedef logic [15:0] sacc_data_t;

endpackage : sacc_pkg

// ===== rtl/sacc_regs.svh
// Constants of the converter control core: codes, field values and limits.
// Assumes it is included by the core and by nothing that redefines these names.
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH

// ----------------------------------------------------------------------------
// Resolution select codes
// ----------------------------------------------------------------------------
`define SACC_RES_12        2'h0
`define SACC_RES_10        2'h1
`define SACC_RES_8         2'h2
`define SACC_RES_6         2'h3

// ----------------------------------------------------------------------------
// Channel map: 0..9 external inputs, then two internal sources
// ----------------------------------------------------------------------------
`define SACC_CH_TEMP       4'ha
`define SACC_CH_VREF       4'hb
`define SACC_CH_COUNT      4'hc

// ----------------------------------------------------------------------------
// Oversampler limits and reset values
// ----------------------------------------------------------------------------
`define SACC_OS_SHIFT_MAX  4'h8
`define SACC_ACC_ZERO      20'h00000
`define SACC_DATA_ZERO     16'h0000
`define SACC_CODE_ZERO     12'h000

`endif

// ===== test/sacc_afe_model.sv
// Behavioural analog front end: answers sample and calibrate requests of the core.
// Assumes it shares the core's clock; the bench reads raw_q and chan_q by hierarchy.
`timescale 1ns/1ps

module sacc_afe_model (
    input  wire logic                 clk,
    input  wire logic                 afe_power_on,
    input  wire sacc_pkg::sacc_chan_t afe_channel,
    input  wire logic                 afe_sample,
    input  wire logic                 afe_calibrate,
    input  wire logic [31:0]          max_delay,
    output logic                      afe_done,
    output sacc_pkg::sacc_code_t      afe_result
);
    import sacc_pkg::*;

    sacc_code_t raw_q[$];
    sacc_chan_t chan_q[$];

    // Result is held well past the done edge, then inverted so a late read shows
    initial begin
        afe_done = 1'b0;
        afe_result = 12'h5a5;
        forever begin
            @(posedge clk);
            if (afe_power_on && (afe_sample || afe_calibrate)) begin
                if (afe_sample) chan_q.push_back(afe_channel);
                repeat ($urandom_range(max_delay, 1)) @(posedge clk);
                afe_result <= 12'($urandom);
                @(posedge clk);
                afe_done <= 1'b1;
                raw_q.push_back(afe_result);
                repeat (4) @(posedge clk);
                afe_done <= 1'b0;
                afe_result <= ~afe_result;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule // sacc_afe_model

// ===== test/sacc_core_test.sv
// Self-checking bench of the converter control core with a behavioural front end.
// Assumes the core, its package and header; inputs change on the falling edge.
`timescale 1ns/1ps
`include "sacc_regs.svh"

module sacc_core_test;
    import sacc_pkg::*;

    logic clk, rst, converter_on, calibration_start, calibration_factor_reset, sw_start;
    logic hw_trigger_enable, hw_trigger, continuous_mode, left_align, oversample_enable;
    logic watchdog_enable, conversion_done_irq_enable, watchdog_irq_enable, eoc_clear, wde_clear;
    logic afe_done, afe_power_on, afe_sample, afe_calibrate, calibration_busy, conversion_busy;
    logic eoc_flag, wde_flag, irq;
    logic [1:0]  resolution;
    logic [2:0]  oversample_ratio;
    logic [3:0]  sequence_length, oversample_shift;
    logic [63:0] sequence_channels;
    sacc_code_t  watchdog_high, watchdog_low, afe_result;
    sacc_chan_t  afe_channel;
    sacc_data_t  result_data;
    int          miscompares, checks, cycles, cal, max_delay;

    sacc_core i_sacc_core (.clk, .rst, .converter_on, .calibration_start, .calibration_factor_reset, .sw_start,
        .hw_trigger_enable, .hw_trigger, .continuous_mode, .left_align, .resolution, .sequence_length,
        .sequence_channels, .oversample_enable, .oversample_ratio, .oversample_shift, .watchdog_enable,
        .watchdog_high, .watchdog_low, .conversion_done_irq_enable, .watchdog_irq_enable, .eoc_clear, .wde_clear,
        .afe_done, .afe_result, .afe_power_on, .afe_channel, .afe_sample, .afe_calibrate, .calibration_busy,
        .conversion_busy, .result_data, .eoc_flag, .wde_flag, .irq);
    sacc_afe_model i_sacc_afe_model (.clk(clk), .afe_power_on(afe_power_on), .afe_channel(afe_channel),
        .afe_sample(afe_sample), .afe_calibrate(afe_calibrate), .max_delay(max_delay),
        .afe_done(afe_done), .afe_result(afe_result));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Inputs are synchronised, so pulses stay high and low for three cycles
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        repeat (3) @(negedge clk);
        s = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    endtask

    task automatic power(input logic on);
        @(negedge clk) converter_on = on;
        repeat (17) @(negedge clk);
        check(afe_power_on, on);
        cal = 0;
        i_sacc_afe_model.raw_q.delete();
        i_sacc_afe_model.chan_q.delete();
    endtask

    task automatic calibrate();
        @(negedge clk) calibration_start = 1'b1;
        wait_for(calibration_busy, 1'b1, 12);
        check(calibration_busy, 1'b1);
        repeat (2) @(negedge clk);
        calibration_start = 1'b0;
        wait_for(calibration_busy, 1'b0, 300);
        check(calibration_busy, 1'b0);
        cal = i_sacc_afe_model.raw_q.pop_front();
        repeat (3) @(negedge clk);
    endtask

    // One routine sequence, checked against a model of the rules; os < 0 means no oversampling
    task automatic run(input bit hw, input int len, input int res, input bit la, input int os, input int shf);
        int n, acc, red, exp_res, lsh;
        bit exp_wde;
        logic [3:0] ch;
        @(negedge clk);
        sequence_length = 4'(len);
        resolution = 2'(res);
        left_align = la;
        oversample_enable = (os >= 0);
        oversample_ratio = 3'(os);
        oversample_shift = 4'(shf);
        sequence_channels = {$urandom, $urandom};
        watchdog_enable = (os < 0);
        watchdog_low = 12'($urandom_range(1023, 0));
        watchdog_high = 12'($urandom_range(4095, 3072));
        conversion_done_irq_enable = 1'($urandom);
        watchdog_irq_enable = 1'($urandom);
        repeat (3) @(negedge clk);
        if (hw) pulse(hw_trigger);
        else pulse(sw_start);
        wait_for(eoc_flag, 1'b1, 9000);
        repeat (2) @(negedge clk);
        n = (os < 0) ? 1 : (2 << os);
        exp_wde = 1'b0;
        for (int k = 0; k <= len; k++) begin
            ch = sequence_channels[4*k +: 4];
            acc = 0;
            for (int r = 0; r < n; r++) begin
                check(i_sacc_afe_model.chan_q.pop_front(), (ch > `SACC_CH_VREF) ? 4'h0 : ch);
                acc += (i_sacc_afe_model.raw_q[0] > cal) ? i_sacc_afe_model.raw_q[0] - cal : 0;
                void'(i_sacc_afe_model.raw_q.pop_front());
            end
            red = acc >> (2 * res);
            if (os < 0 && (red > watchdog_high || red < watchdog_low)) exp_wde = 1'b1;
        end
        lsh = (res == 3) ? 2 : 4 + 2 * res;
        exp_res = (os >= 0) ? (acc >> ((shf > 8) ? 8 : shf)) & 16'hffff : (la ? red << lsh : red);
        check(result_data, 20'(exp_res));
        check(eoc_flag, 1'b1);
        check(wde_flag, exp_wde);
        check(irq, conversion_done_irq_enable | (watchdog_irq_enable & exp_wde));
        repeat (30) @(negedge clk);
        check(conversion_busy, 1'b0);
        check(20'(i_sacc_afe_model.chan_q.size()), 20'h00000);
        pulse(eoc_clear);
        pulse(wde_clear);
        check({eoc_flag, wde_flag}, 2'h0);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {converter_on, calibration_start, calibration_factor_reset, sw_start, hw_trigger_enable} = '0;
        {hw_trigger, continuous_mode, left_align, oversample_enable, watchdog_enable} = '0;
        {conversion_done_irq_enable, watchdog_irq_enable, eoc_clear, wde_clear} = '0;
        {resolution, oversample_ratio, sequence_length, oversample_shift, sequence_channels} = '0;
        {watchdog_high, watchdog_low} = '0;
        rst = 1'b1;
        max_delay = 1;
        void'($urandom(5));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({afe_power_on, afe_sample, afe_calibrate, calibration_busy, conversion_busy}, 5'h00);
        check({eoc_flag, wde_flag, irq, result_data}, 19'h00000);
        power(1'b1);
        pulse(hw_trigger);
        repeat (5) @(negedge clk);
        check(conversion_busy, 1'b0);
        calibrate();
        hw_trigger_enable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            max_delay = 1 + 5 * (i % 2);
            run(i[0], $urandom_range(3, 0), i / 2, 1'($urandom), -1, 0);
        end
        run(1'b0, 15, 0, 1'b0, -1, 0);
        run(1'b0, 0, 0, 1'b0, 0, 1);
        run(1'b0, 1, 0, 1'b1, 7, 15);
        pulse(calibration_factor_reset);
        cal = 0;
        run(1'b0, 0, 0, 1'b0, -1, 0);
        pulse(calibration_factor_reset);
        calibrate();
        run(1'b0, 2, 0, 1'b0, -1, 0);
        power(1'b0);
        power(1'b1);
        run(1'b0, 0, 0, 1'b0, -1, 0);
        continuous_mode = 1'b1;
        pulse(sw_start);
        wait_for(eoc_flag, 1'b1, 4000);
        pulse(eoc_clear);
        wait_for(eoc_flag, 1'b1, 4000);
        check(eoc_flag, 1'b1);
        power(1'b0);
        check({conversion_busy, eoc_flag, afe_sample}, 3'h0);
        end_of_test();
    end
endmodule // sacc_core_test
